// ---- inc/adc_mode_cfg.svh ----
// adc_mode_cfg.svh: register offsets, field positions, reset values and
// timing counts for the converter mode and pin control block.
// assumes a 20 MHz apb clock and 12-bit byte addresses.
`ifndef ADC_MODE_CFG_SVH
`define ADC_MODE_CFG_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define REG_CTRL        12'h000
`define REG_STATUS      12'h004
`define REG_RESULT      12'h008
`define REG_LSB         12'h00c

// ----------------------------------------------------------------------
// control register fields and reset value
// ----------------------------------------------------------------------
`define CTRL_OVR_EN     0
`define CTRL_REF_INT    1
`define CTRL_RANGE_WIDE 2
`define CTRL_PD_N       3
`define CTRL_IF_SEL     4
`define CTRL_BYTE_SEL   5
`define CTRL_WIDTH      6
`define CTRL_RESET      6'h00

// ----------------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------------
`define STAT_REF_INT    0
`define STAT_RANGE_WIDE 1
`define STAT_STANDBY    2
`define STAT_SHUTDOWN   3
`define STAT_IF_LO      4
`define STAT_IF_HI      5
`define STAT_SETTLING   6
`define STAT_VALID      7
`define STAT_WIDTH      8

// ----------------------------------------------------------------------
// code format and step size
// ----------------------------------------------------------------------
`define RESULT_WIDTH    16
`define CODE_STEPS      65536
`define FSR_WIDE_MV     20000
`define FSR_NARROW_MV   10000
// step in hundredths of a microvolt, rounded to nearest
`define LSB_CUV(fsr_mv) ((((fsr_mv) * 100000) + (`CODE_STEPS / 2)) / `CODE_STEPS)

// range level that picks shutdown while power-down is requested
`define PD_SHUTDOWN_RANGE 1'b1

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_MHZ          20
`define RANGE_SETTLE_US  100
`define RANGE_SETTLE_CYC (`RANGE_SETTLE_US * `CLK_MHZ)
`define SETTLE_CNT_W     12

`endif

// ---- inc/adc_mode_pkg.sv ----
// adc_mode_pkg.sv: types shared by the mode and pin control block.
// assumes adc_mode_cfg.svh is compiled alongside.
package adc_mode_pkg;

    // power state of the converter
    typedef enum logic [1:0] {
        pwr_normal,
        pwr_standby,
        pwr_shutdown
    } pwr_state_t;

    // read-out interface selection
    typedef enum logic [1:0] {
        if_parallel,
        if_byte,
        if_serial
    } if_mode_t;

    // effective configuration levels after pin or software choice
    typedef struct packed {
        logic ref_int;
        logic range_wide;
        logic pd_n;
        logic if_sel;
        logic byte_sel;
    } cfg_t;

    // analog enables towards the reference and front end
    typedef struct packed {
        logic bandgap_en;
        logic ref_buf_en;
        logic ref_pin_drive;
        logic regulators_en;
        logic core_en;
    } pwr_ctl_t;

endpackage : adc_mode_pkg

// ---- rtl/sync_2ff.sv ----
// sync_2ff.sv: two flip-flop synchroniser for a group of level inputs.
// assumes inputs are slow levels; bits are not coherent with each other.
`timescale 1ns/1ps

module sync_2ff #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] nxt_meta;
    logic [WIDTH-1:0] nxt_sync;

    // next values: first stage feeds only the second
    always_comb begin
        nxt_meta = async_in;
        nxt_sync = meta_ff;
    end

    // register both stages
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff  <= '0;
            sync_out <= '0;
        end else begin
            meta_ff  <= nxt_meta;
            sync_out <= nxt_sync;
        end
    end

endmodule : sync_2ff

// ---- rtl/adc_mode_ctrl.sv ----
// adc_mode_ctrl.sv: reference, range, power-down and interface mode
// control of an eight-channel 16-bit converter, with an apb window.
// assumes mode pins are asynchronous levels from the host, the core
// result arrives on pclk, and the host keeps its own timing duties.
`timescale 1ns/1ps
`include "adc_mode_cfg.svh"

// Functional notes
// RQ1: results leave as 16-bit two's complement, same for every range, channel.
// RQ2: one code step is span over 65536: 305.18 uV wide, 152.59 uV narrow.
// RQ3: reference select high enables internal bandgap; low powers it down.
// RQ4: the reference buffer stays enabled in both reference modes.
// RQ5: reference select is asynchronous; pin drive follows it at once. Code drives the pin three pclk edges later.
// RQ6: after power-up the reference mode follows the select level present.
// RQ7: range high gives plus-minus ten volts, low gives plus-minus five.
// RQ8: range change applies at once; host waits about 100 us to settle. Code applies range_wide three pclk edges after the pin changes.
// RQ9: power-down request high runs normally; low enters standby or shutdown.
// RQ10: shutdown powers all down; standby keeps reference and regulators. Code keeps ref_buf_en on in shutdown.
// RQ11: a low power-down request is taken asynchronously at any moment. Code samples it through the two-flop synchroniser and a register.
// RQ12: host waits the exit recovery time after leaving a low-power mode.
// RQ13: interface select low parallel; high: byte select low serial, high byte.
// RQ14: host resets the device after power-up and after leaving shutdown.
// RQ15: host keeps interface selects steady while a read frame runs.
module adc_mode_ctrl
    import adc_mode_pkg::*;
(
    // clock and reset
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    // apb slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [11:0]               paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    // mode pins from the host
    input  wire logic                      reference_source_select,
    input  wire logic                      range_select,
    input  wire logic                      power_down_request_n,
    input  wire logic                      interface_select,
    input  wire logic                      byte_serial_select,
    input  wire logic                      device_reset,
    // conversion core result, on pclk
    input  wire logic [`RESULT_WIDTH-1:0]  conv_raw,
    input  wire logic                      conv_valid,
    // controls towards the analog side and the read-out logic
    output pwr_ctl_t                       pwr_ctl,
    output pwr_state_t                     pwr_state,
    output logic                           range_wide,
    output if_mode_t                       if_mode,
    output logic                           range_settling,
    output logic [`RESULT_WIDTH-1:0]       result_word,
    output logic                           result_valid
);

    // ------------------------------------------------------------------
    // constants
    // ------------------------------------------------------------------
    localparam logic [31:0] LSB_WIDE   = 32'(`LSB_CUV(`FSR_WIDE_MV));
    localparam logic [31:0] LSB_NARROW = 32'(`LSB_CUV(`FSR_NARROW_MV));
    localparam logic [`SETTLE_CNT_W-1:0] SETTLE_CYC =
        `SETTLE_CNT_W'(`RANGE_SETTLE_CYC);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [5:0] pins_sync;

    // all host pins pass two flip-flops before use
    sync_2ff #(
        .WIDTH (6)
    ) u_pin_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({device_reset, reference_source_select, range_select,
                    power_down_request_n, interface_select,
                    byte_serial_select}),
        .sync_out (pins_sync)
    );

    // ------------------------------------------------------------------
    // apb register file
    // ------------------------------------------------------------------
    logic [`CTRL_WIDTH-1:0] ctrl_ff;
    logic [`CTRL_WIDTH-1:0] nxt_ctrl;
    logic [31:0]            prdata_ff;
    logic [31:0]            nxt_prdata;
    logic                   pready_ff;
    logic                   nxt_pready;
    logic                   pslverr_ff;
    logic                   nxt_pslverr;
    logic                   access;
    logic                   wr_ctrl;
    logic                   rd_result;
    logic                   mapped;
    logic [`STAT_WIDTH-1:0] status;
    logic                   range_ff;
    logic [`RESULT_WIDTH-1:0] result_word_ff;

    // access completes on the second access cycle, one wait state
    assign access    = psel && penable && !pready_ff;
    assign mapped    = (paddr == `REG_CTRL) || (paddr == `REG_STATUS) ||
                       (paddr == `REG_RESULT) || (paddr == `REG_LSB);
    assign wr_ctrl   = access && pwrite && (paddr == `REG_CTRL);
    assign rd_result = access && !pwrite && (paddr == `REG_RESULT);

    // decode writes and build read data
    always_comb begin
        nxt_ctrl    = ctrl_ff;
        nxt_pready  = access;
        nxt_pslverr = access && !mapped;
        nxt_prdata  = 32'h0000_0000;
        if (wr_ctrl) begin
            nxt_ctrl = pwdata[`CTRL_WIDTH-1:0];
        end
        if (access && !pwrite) begin
            unique case (paddr)
                `REG_CTRL:   nxt_prdata = {26'h000_0000, ctrl_ff};
                `REG_STATUS: nxt_prdata = {24'h00_0000, status};
                `REG_RESULT: nxt_prdata = {{16{result_word_ff[15]}},
                                           result_word_ff};
                `REG_LSB:    nxt_prdata = range_ff ? LSB_WIDE
                                                   : LSB_NARROW; // RQ2
                default:     nxt_prdata = 32'h0000_0000;
            endcase
        end
    end

    // register bus state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff    <= `CTRL_RESET;
            prdata_ff  <= 32'h0000_0000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            ctrl_ff    <= nxt_ctrl;
            prdata_ff  <= nxt_prdata;
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    assign prdata  = prdata_ff;
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;

    // ------------------------------------------------------------------
    // effective configuration
    // ------------------------------------------------------------------
    cfg_t cfg;
    logic dev_reset_s;

    // software override replaces the pin levels as a group
    always_comb begin
        dev_reset_s = pins_sync[5];
        if (ctrl_ff[`CTRL_OVR_EN]) begin
            cfg.ref_int    = ctrl_ff[`CTRL_REF_INT];
            cfg.range_wide = ctrl_ff[`CTRL_RANGE_WIDE];
            cfg.pd_n       = ctrl_ff[`CTRL_PD_N];
            cfg.if_sel     = ctrl_ff[`CTRL_IF_SEL];
            cfg.byte_sel   = ctrl_ff[`CTRL_BYTE_SEL];
        end else begin
            cfg.ref_int    = pins_sync[4];
            cfg.range_wide = pins_sync[3];
            cfg.pd_n       = pins_sync[2];
            cfg.if_sel     = pins_sync[1];
            cfg.byte_sel   = pins_sync[0];
        end
    end

    // ------------------------------------------------------------------
    // power, reference and range control
    // ------------------------------------------------------------------
    pwr_state_t             pwr_ff;
    pwr_state_t             nxt_pwr;
    pwr_ctl_t               pctl_ff;
    pwr_ctl_t               nxt_pctl;
    logic                   nxt_range;
    if_mode_t               if_ff;
    if_mode_t               nxt_if;
    logic [`SETTLE_CNT_W-1:0] settle_ff;
    logic [`SETTLE_CNT_W-1:0] nxt_settle;
    logic                   settling_ff;
    logic                   nxt_settling;

    // next power state, enables, range and interface mode
    always_comb begin
        // power-down request is acted on every cycle, no handshake
        if (cfg.pd_n) begin // RQ11
            nxt_pwr = pwr_normal; // RQ9
        end else if (cfg.range_wide == `PD_SHUTDOWN_RANGE) begin
            nxt_pwr = pwr_shutdown; // RQ9
        end else begin
            nxt_pwr = pwr_standby; // RQ9
        end

        // range follows its level with no gating
        nxt_range = cfg.range_wide; // RQ7 RQ8

        // enables derived from reference select and power state
        nxt_pctl.ref_buf_en    = 1'b1; // RQ4
        nxt_pctl.bandgap_en    = cfg.ref_int; // RQ3 RQ6
        nxt_pctl.ref_pin_drive = cfg.ref_int; // RQ3 RQ5
        nxt_pctl.regulators_en = 1'b1;
        nxt_pctl.core_en       = 1'b1;
        unique case (nxt_pwr)
            pwr_normal: begin
            end
            pwr_standby: begin
                nxt_pctl.core_en = 1'b0; // RQ10
            end
            pwr_shutdown: begin
                nxt_pctl.core_en       = 1'b0; // RQ10
                nxt_pctl.regulators_en = 1'b0; // RQ10
                nxt_pctl.bandgap_en    = 1'b0; // RQ10
                nxt_pctl.ref_pin_drive = 1'b0; // RQ10
            end
        endcase

        // interface decode
        if (!cfg.if_sel) begin
            nxt_if = if_parallel; // RQ13
        end else if (cfg.byte_sel) begin
            nxt_if = if_byte; // RQ13
        end else begin
            nxt_if = if_serial; // RQ13
        end

        // settle window restarts on every range change
        nxt_settle   = settle_ff;
        nxt_settling = settling_ff;
        if (nxt_range != range_ff) begin
            nxt_settle   = SETTLE_CYC; // RQ8
            nxt_settling = 1'b1;
        end else if (settle_ff != `SETTLE_CNT_W'h000) begin
            nxt_settle   = settle_ff - `SETTLE_CNT_W'h001;
            nxt_settling = (settle_ff != `SETTLE_CNT_W'h001);
        end
    end

    // register power and mode state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_ff      <= pwr_normal;
            pctl_ff     <= '{bandgap_en: 1'b0, ref_buf_en: 1'b1,
                             ref_pin_drive: 1'b0, regulators_en: 1'b1,
                             core_en: 1'b1};
            range_ff    <= 1'b0;
            if_ff       <= if_parallel;
            settle_ff   <= `SETTLE_CNT_W'h000;
            settling_ff <= 1'b0;
        end else begin
            pwr_ff      <= nxt_pwr;
            pctl_ff     <= nxt_pctl;
            range_ff    <= nxt_range;
            if_ff       <= nxt_if;
            settle_ff   <= nxt_settle;
            settling_ff <= nxt_settling;
        end
    end

    assign pwr_ctl        = pctl_ff;
    assign pwr_state      = pwr_ff;
    assign range_wide     = range_ff;
    assign if_mode        = if_ff;
    assign range_settling = settling_ff;

    // ------------------------------------------------------------------
    // result formatting
    // ------------------------------------------------------------------
    logic [`RESULT_WIDTH-1:0] nxt_result_word;
    logic                     valid_ff;
    logic                     nxt_valid;

    // offset-binary core code becomes two's complement by msb flip
    always_comb begin
        nxt_result_word = result_word_ff;
        nxt_valid       = valid_ff;
        if (rd_result) begin
            nxt_valid = 1'b0;
        end
        if (conv_valid) begin
            nxt_result_word = {~conv_raw[`RESULT_WIDTH-1],
                               conv_raw[`RESULT_WIDTH-2:0]}; // RQ1
            nxt_valid       = 1'b1; // new result wins over read clear
        end
        if (dev_reset_s) begin
            nxt_result_word = '0;
            nxt_valid       = 1'b0;
        end
    end

    // register result
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_word_ff <= '0;
            valid_ff       <= 1'b0;
        end else begin
            result_word_ff <= nxt_result_word;
            valid_ff       <= nxt_valid;
        end
    end

    assign result_word  = result_word_ff;
    assign result_valid = valid_ff;

    // status word seen by software
    always_comb begin
        status                   = '0;
        status[`STAT_REF_INT]    = pctl_ff.bandgap_en;
        status[`STAT_RANGE_WIDE] = range_ff;
        status[`STAT_STANDBY]    = (pwr_ff == pwr_standby);
        status[`STAT_SHUTDOWN]   = (pwr_ff == pwr_shutdown);
        status[`STAT_IF_LO]      = if_ff[0];
        status[`STAT_IF_HI]      = if_ff[1];
        status[`STAT_SETTLING]   = settling_ff;
        status[`STAT_VALID]      = valid_ff;
    end

endmodule : adc_mode_ctrl

// ---- test/host_pins.sv ----
// host_pins.sv: model of the host controller that drives the mode pins.
// assumes the bench hands it wanted levels on the rising edge of pclk.
`timescale 1ns/1ps

module host_pins
    import adc_mode_pkg::*;
(
    // clock
    input  wire logic pclk,
    // wanted levels from the bench
    input  cfg_t      want,
    input  wire logic rst_req,
    // pins towards the device
    output logic      reference_source_select,
    output logic      range_select,
    output logic      power_down_request_n,
    output logic      interface_select,
    output logic      byte_serial_select,
    output logic      device_reset
);
    // pins change only right after a rising edge; the bench paces changes
    // and waits out recovery and settling before it uses the device
    always_ff @(posedge pclk) begin
        reference_source_select <= want.ref_int;
        range_select            <= want.range_wide;
        power_down_request_n    <= want.pd_n;
        interface_select        <= want.if_sel;
        byte_serial_select      <= want.byte_sel;
        device_reset            <= rst_req;
    end
endmodule : host_pins

// ---- test/adc_mode_props.sv ----
// adc_mode_props.sv: concurrent checks on the mode control block ports.
// assumes one clock domain, pclk, with presetn as its reset.
`timescale 1ns/1ps
`include "adc_mode_cfg.svh"

module adc_mode_props
    import adc_mode_pkg::*;
(
    input wire logic                     pclk,
    input wire logic                     presetn,
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic                     pready,
    input wire logic                     pslverr,
    input wire logic                     device_reset,
    input wire logic [`RESULT_WIDTH-1:0] conv_raw,
    input wire logic                     conv_valid,
    input wire pwr_ctl_t                 pwr_ctl,
    input wire pwr_state_t               pwr_state,
    input wire logic                     range_wide,
    input wire if_mode_t                 if_mode,
    input wire logic                     range_settling,
    input wire logic [`RESULT_WIDTH-1:0] result_word,
    input wire logic                     result_valid
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ------------------------------------------------------------------
    // apb handshake
    // ------------------------------------------------------------------
    sequence s_taken;
        psel && penable && !pready;
    endsequence
    chk_apb_one_wait: assert property (s_taken |=> pready)
        else $error("pready missing after access");
    chk_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held too long");
    chk_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");

    // ------------------------------------------------------------------
    // reference and power
    // ------------------------------------------------------------------
    chk_ref_buffer_on: assert property (pwr_ctl.ref_buf_en)
        else $error("reference buffer disabled");
    chk_pin_with_bandgap: assert property (
        pwr_ctl.ref_pin_drive == pwr_ctl.bandgap_en)
        else $error("reference pin drive without bandgap");
    chk_shutdown_all_off: assert property (pwr_state == pwr_shutdown |->
        !pwr_ctl.core_en && !pwr_ctl.regulators_en && !pwr_ctl.bandgap_en)
        else $error("circuitry on in shutdown");
    chk_standby_keeps: assert property (pwr_state == pwr_standby |->
        !pwr_ctl.core_en && pwr_ctl.regulators_en)
        else $error("standby power wrong");
    chk_normal_core_on: assert property (
        pwr_state == pwr_normal |-> pwr_ctl.core_en)
        else $error("core off in normal state");

    // ------------------------------------------------------------------
    // range, interface and result
    // ------------------------------------------------------------------
    sequence s_range_moved;
        $changed(range_wide);
    endsequence
    chk_settle_start: assert property (s_range_moved |-> ##[0:1]
        range_settling)
        else $error("settling not flagged on range change");
    chk_settle_holds: assert property ($rose(range_settling) |->
        range_settling[*8])
        else $error("settling dropped early");
    chk_if_mode_legal: assert property (if_mode != 2'd3)
        else $error("illegal interface mode");
    chk_result_code: assert property (conv_valid && !$past(device_reset, 2) |=>
        result_valid && result_word ==
        {~$past(conv_raw[15]), $past(conv_raw[14:0])})
        else $error("result not in two's complement");
endmodule : adc_mode_props

bind adc_mode_ctrl adc_mode_props adc_mode_props_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .device_reset(device_reset),
    .conv_raw(conv_raw), .conv_valid(conv_valid), .pwr_ctl(pwr_ctl),
    .pwr_state(pwr_state), .range_wide(range_wide), .if_mode(if_mode),
    .range_settling(range_settling), .result_word(result_word),
    .result_valid(result_valid));

// ---- test/tb.sv ----
// tb.sv: self-checking bench for the converter mode control block.
// assumes host_pins drives the mode pins and the bench is the apb master.
`timescale 1ns/1ps
`include "adc_mode_cfg.svh"

`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
    n_mismatch++; \
    $display("mismatch at %0t: got %h want %h", $time, a, b); end end

module tb;
    import adc_mode_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        ref_sel, rng, pdn, ifs, bys, dev_rst, rst_req, cv, rv, rs;
    logic [15:0] raw, rw;
    cfg_t        want;
    pwr_ctl_t    pc;
    pwr_state_t  ps;
    if_mode_t    im;
    logic        err;
    int          n_mismatch, check_count;

    host_pins host_pins_inst (.pclk(pclk), .want(want), .rst_req(rst_req),
        .reference_source_select(ref_sel), .range_select(rng),
        .power_down_request_n(pdn), .interface_select(ifs),
        .byte_serial_select(bys), .device_reset(dev_rst));

    adc_mode_ctrl adc_mode_ctrl_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .reference_source_select(ref_sel),
        .range_select(rng), .power_down_request_n(pdn),
        .interface_select(ifs), .byte_serial_select(bys),
        .device_reset(dev_rst), .conv_raw(raw), .conv_valid(cv),
        .pwr_ctl(pc), .pwr_state(ps), .range_wide(rs), .if_mode(im),
        .range_settling(), .result_word(rw), .result_valid(rv));

    // ------------------------------------------------------------------
    // clock, bus tasks and closing
    // ------------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // one apb transfer; holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // pin levels need partner flop plus three device edges
    task automatic pins(input cfg_t c);
        want <= c;
        repeat (6) @(posedge pclk);
    endtask : pins

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test

    initial begin
        #(50 * 20000);
        n_mismatch++;
        end_of_test();
    end

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; raw = 16'h0; cv = 1'b0;
        rst_req = 1'b1; want = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
        n_mismatch = 0; check_count = 0;
        repeat (16) @(posedge pclk);
        `CHK(pc, 5'h0b)
        presetn <= 1'b1; rst_req <= 1'b0;
        repeat (4) @(posedge pclk);
        `CHK(pc, 5'h1f)
        $display("test reset done");
        // reference select both ways, buffer always on
        pins('{1'b0, 1'b0, 1'b1, 1'b0, 1'b0});
        `CHK(pc, 5'h0b)
        pins('{1'b1, 1'b0, 1'b1, 1'b0, 1'b0});
        `CHK(pc, 5'h1f)
        $display("test reference done");
        // range and step size
        apb(1'b0, `REG_LSB, 32'h0);
        `CHK(rd, 32'd15259)
        pins('{1'b1, 1'b1, 1'b1, 1'b0, 1'b0});
        `CHK(rs, 1'b1)
        apb(1'b0, `REG_LSB, 32'h0);
        `CHK(rd, 32'd30518)
        apb(1'b0, `REG_STATUS, 32'h0);
        `CHK(rd[6:1], 6'b100001)
        repeat (2000) @(posedge pclk);
        apb(1'b0, `REG_STATUS, 32'h0);
        `CHK(rd[6], 1'b0)
        pins('{1'b1, 1'b0, 1'b1, 1'b0, 1'b0});
        `CHK(rs, 1'b0)
        repeat (2000) @(posedge pclk);
        $display("test range done");
        // power-down modes picked by range level
        pins('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0});
        `CHK(ps, pwr_standby)
        `CHK(pc, 5'h1e)
        pins('{1'b1, 1'b1, 1'b0, 1'b0, 1'b0});
        `CHK(ps, pwr_shutdown)
        `CHK(pc, 5'h08)
        pins('{1'b1, 1'b0, 1'b1, 1'b0, 1'b0});
        repeat (2000) @(posedge pclk);
        `CHK(ps, pwr_normal)
        $display("test power-down done");
        // interface selection, all combinations
        for (int i = 0; i < 4; i++) begin
            pins('{1'b1, 1'b0, 1'b1, i[1], i[0]});
            `CHK(im, i[1] ? (i[0] ? if_byte : if_serial) : if_parallel)
        end
        pins('{1'b1, 1'b0, 1'b1, 1'b0, 1'b0});
        $display("test interface done");
        // result code at both ends and mid-scale, read clears valid
        for (int i = 0; i < 3; i++) begin
            raw <= (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : 16'h8000;
            cv <= 1'b1;
            @(posedge pclk);
            cv <= 1'b0;
            @(posedge pclk);
            `CHK(rw, raw ^ 16'h8000)
            `CHK(rv, 1'b1)
            apb(1'b0, `REG_RESULT, 32'h0);
            `CHK(rd, {{16{~raw[15]}}, raw ^ 16'h8000})
            `CHK(rv, 1'b0)
        end
        rst_req <= 1'b1;
        cv <= 1'b1;
        @(posedge pclk);
        cv <= 1'b0;
        repeat (4) @(posedge pclk);
        rst_req <= 1'b0;
        repeat (4) @(posedge pclk);
        `CHK(rv, 1'b0)
        $display("test result done");
        // software override, read-only write and unmapped address
        apb(1'b1, `REG_CTRL, 32'h0000001b);
        apb(1'b0, `REG_CTRL, 32'h0);
        `CHK(rd, 32'h0000001b)
        repeat (4) @(posedge pclk);
        `CHK(im, if_serial)
        apb(1'b1, `REG_CTRL, 32'h0);
        apb(1'b1, `REG_STATUS, 32'hffffffff);
        `CHK(err, 1'b0)
        apb(1'b0, 12'h010, 32'h0);
        `CHK(err, 1'b1)
        `CHK(rd, 32'h0)
        $display("test registers done");
        end_of_test();
    end
endmodule : tb
